// *** ilc_pkg.sv ***
// Package with offsets, fields, reset values and codes of the control and config registers.
package ilc_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_RANGE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0a;
  localparam logic [7:0] ADDR_CFG = 8'h0b;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Control register fields.
  localparam int CTRL_KEY_HI = 7;
  localparam int CTRL_KEY_LO = 6;
  localparam int CTRL_PH_HI = 5;
  localparam int CTRL_PH_LO = 4;
  localparam int CTRL_PH_EN = 3;
  localparam int CTRL_RSV_HI = 2;
  // Configuration register fields.
  localparam int CFG_SRC = 7;
  localparam int CFG_RSV = 6;
  localparam int CFG_LOCK = 5;
  localparam int CFG_FMT = 4;
  localparam int CFG_OFFSET_MONITOR_ENABLE = 3;
  localparam int CFG_ARM_HI = 2;
  // Reset key codes, sent in bits 7:6.
  localparam logic [1:0] KEY_STEP1 = 2'h0;
  localparam logic [1:0] KEY_STEP2 = 2'h3;
  localparam logic [1:0] KEY_STEP3 = 2'h1;
  // Offset cancellation phase codes.
  localparam logic [1:0] PHASE_START1 = 2'h0;
  localparam logic [1:0] PHASE_NORMAL = 2'h3;
  // Arming pin modes as decoded from the three-bit field.
  localparam logic [2:0] ARM_OFF = 3'h0;
  localparam logic [2:0] ARM_PCM = 3'h1;
  localparam logic [2:0] ARM_AVG = 3'h2;
  localparam logic [2:0] ARM_COUNT = 3'h3;
  localparam logic [2:0] ARM_UNFILT = 3'h4;
  // Key sequencer states.
  typedef enum logic [2:0] {
    ILC_KEY_IDLE = 3'b001,
    ILC_KEY_ONE = 3'b010,
    ILC_KEY_TWO = 3'b100
  } ilc_key_e;
endpackage

// *** ilc_reset_key.sv ***
// Three-write reset key sequencer for the control register.
`timescale 1ns/1ps
`default_nettype none
module ilc_reset_key (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Command seen by the register bank
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [1:0] cmd_key,
  // Internal digital reset request, one cycle
  output logic key_fire
);
  ilc_pkg::ilc_key_e state_reg;
  logic ctrl_wr;

  assign ctrl_wr = cmd_valid && cmd_write && (cmd_addr == ilc_pkg::ADDR_CTRL);

  // Any other command, including a control read, drops the sequence.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ilc_pkg::ILC_KEY_IDLE;
    end else if (cmd_valid) begin
      if (ctrl_wr && cmd_key == ilc_pkg::KEY_STEP1) begin
        state_reg <= ilc_pkg::ILC_KEY_ONE;
      end else begin
        case (state_reg)
          ilc_pkg::ILC_KEY_ONE: begin
            if (ctrl_wr && cmd_key == ilc_pkg::KEY_STEP2) begin
              state_reg <= ilc_pkg::ILC_KEY_TWO;
            end else begin
              state_reg <= ilc_pkg::ILC_KEY_IDLE;
            end
          end
          default: begin
            state_reg <= ilc_pkg::ILC_KEY_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_fire <= 1'b0;
    end else begin
      key_fire <= ctrl_wr && (state_reg == ilc_pkg::ILC_KEY_TWO) &&
        (cmd_key == ilc_pkg::KEY_STEP3);
    end
  end
endmodule
`default_nettype wire

// *** ilc_regs.sv ***
// Control, configuration and range code registers with the initialization lock.
// Operation
// - Writes of key 00, 11, 01 to control, back to back, reset the digital core.
// - Any other command or wrong key between them abandons the key sequence.
// - Control write response shows zero key bits and held bits 5 to 0.
// - Reading the control register gives zero key bits and cancels the sequence.
// - Key bits always writable; bits 5 to 0 ignored once locked.
// - After lock, control reads show phase values accepted before locking.
// - Phase field accepted only while unlocked and override enable is one.
// - Enabled override holds offset cancellation in the written phase.
// - With override off, phase writes are ignored and progression continues.
// - Lock forces normal phase; stored phase and enable stay unchanged.
// - Lock inhibits writes to the whole configuration register.
// - Lock bit is set by a write and cleared only by reset or by the key reset.
// - Register integrity check runs only while locked.
// - Lock disables self test; stored self test bit is unchanged.
// - Data source bit selects offset-cancelled (0) or raw (1) output.
// - Offset-cancelled data forces the offset monitor on.
// - Format bit one gives unsigned data, zero gives signed data.
// - Offset monitor enable bit turns the monitor on or off.
// - Arming field selects off, modulated code, average, count or unfiltered.
// - Lowest arming bit gives polarity in average, count and unfiltered modes; disabled mode floats the pin.
// - Range code register is read-only and steers nothing.
`timescale 1ns/1ps
`default_nettype none
module ilc_regs #(
  // Range variant code; the default is arbitrary.
  parameter logic [7:0] RANGE_CODE = 8'h5a
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register command from the serial frame decoder
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  // Register response
  output logic rsp_valid,
  output logic rsp_hit,
  output logic [7:0] rsp_data,
  // Stored self test bit of the axis register
  input wire logic self_test_control,
  // Internal digital reset
  output logic soft_reset,
  // Offset cancellation steering
  output logic phase_hold,
  output logic [1:0] phase_sel,
  // Data path configuration
  output logic data_source_select,
  output logic output_format_select,
  output logic offset_monitor_on,
  // Arming pin configuration
  output logic [2:0] arm_mode,
  output logic arm_active_low,
  output logic arm_drive_en,
  // Lock consequences
  output logic init_lock,
  output logic crc_check_en,
  output logic self_test_en
);
  logic [5:0] ctrl_reg;
  logic [7:0] cfg_reg;
  logic [5:0] ctrl_next;
  logic [7:0] cfg_next;
  logic key_fire;
  logic lock_q;
  logic ctrl_wr;
  logic cfg_wr;
  logic [7:0] rd_mux;
  logic rd_hit;
  logic [2:0] arm_field;

  assign lock_q = cfg_reg[ilc_pkg::CFG_LOCK];
  assign ctrl_wr = cmd_valid && cmd_write && (cmd_addr == ilc_pkg::ADDR_CTRL);
  assign cfg_wr = cmd_valid && cmd_write && (cmd_addr == ilc_pkg::ADDR_CFG);
  assign arm_field = cfg_reg[ilc_pkg::CFG_ARM_HI:0];

  ilc_reset_key u_key (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_addr(cmd_addr),
    .cmd_key(cmd_wdata[ilc_pkg::CTRL_KEY_HI:ilc_pkg::CTRL_KEY_LO]),
    .key_fire(key_fire)
  );

  // Control bits 5 to 0; the phase field also needs the stored enable.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr && !lock_q) begin
      ctrl_next[ilc_pkg::CTRL_PH_EN] = cmd_wdata[ilc_pkg::CTRL_PH_EN];
      ctrl_next[ilc_pkg::CTRL_RSV_HI:0] = cmd_wdata[ilc_pkg::CTRL_RSV_HI:0];
      if (ctrl_reg[ilc_pkg::CTRL_PH_EN]) begin
        ctrl_next[ilc_pkg::CTRL_PH_HI:ilc_pkg::CTRL_PH_LO] =
          cmd_wdata[ilc_pkg::CTRL_PH_HI:ilc_pkg::CTRL_PH_LO];
      end
    end
  end

  // Lock is cleared only by reset or by the key reset; the whole configuration register freezes behind it.
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr && !lock_q) begin
      cfg_next = cmd_wdata;
    end
  end

  // The key reset clears the bank one cycle after the third write.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= ilc_pkg::CTRL_RST[5:0];
    end else if (key_fire) begin
      ctrl_reg <= ilc_pkg::CTRL_RST[5:0];
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= ilc_pkg::CFG_RST;
    end else if (key_fire) begin
      cfg_reg <= ilc_pkg::CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Responses carry the contents held before the command; key bits read zero.
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    case (cmd_addr)
      ilc_pkg::ADDR_RANGE: rd_mux = RANGE_CODE;
      ilc_pkg::ADDR_CTRL: rd_mux = {2'h0, ctrl_reg};
      ilc_pkg::ADDR_CFG: rd_mux = cfg_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_hit <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_hit <= cmd_valid && rd_hit;
      rsp_data <= cmd_valid ? rd_mux : 8'h00;
    end
  end

  assign soft_reset = key_fire;

  // Offset cancellation: lock forces normal, else the override holds a phase.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_hold <= 1'b0;
      phase_sel <= ilc_pkg::PHASE_START1;
    end else if (lock_q) begin
      phase_hold <= 1'b1;
      phase_sel <= ilc_pkg::PHASE_NORMAL;
    end else begin
      phase_hold <= ctrl_reg[ilc_pkg::CTRL_PH_EN];
      phase_sel <= ctrl_reg[ilc_pkg::CTRL_PH_HI:ilc_pkg::CTRL_PH_LO];
    end
  end

  // Data path selections.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_source_select <= 1'b0;
      output_format_select <= 1'b0;
      offset_monitor_on <= 1'b1;
    end else begin
      data_source_select <= cfg_reg[ilc_pkg::CFG_SRC];
      output_format_select <= cfg_reg[ilc_pkg::CFG_FMT];
      offset_monitor_on <= cfg_reg[ilc_pkg::CFG_OFFSET_MONITOR_ENABLE] ||
        !cfg_reg[ilc_pkg::CFG_SRC];
    end
  end

  // Arming pin mode and polarity.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_mode <= ilc_pkg::ARM_OFF;
      arm_active_low <= 1'b0;
      arm_drive_en <= 1'b0;
    end else begin
      case (arm_field[2:1])
        2'h0: arm_mode <= arm_field[0] ? ilc_pkg::ARM_PCM : ilc_pkg::ARM_OFF;
        2'h1: arm_mode <= ilc_pkg::ARM_AVG;
        2'h2: arm_mode <= ilc_pkg::ARM_COUNT;
        default: arm_mode <= ilc_pkg::ARM_UNFILT;
      endcase
      // The modulated code output is plain digital, so it has no polarity.
      arm_active_low <= (arm_field[2:1] != 2'h0) && arm_field[0];
      arm_drive_en <= (arm_field != 3'h0);
    end
  end

  // Lock consequences.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_lock <= 1'b0;
      crc_check_en <= 1'b0;
      self_test_en <= 1'b0;
    end else begin
      init_lock <= lock_q;
      crc_check_en <= lock_q;
      self_test_en <= self_test_control && !lock_q;
    end
  end

  // Checks and coverage.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // A separate count of key steps taken, kept only for the checks below, so that
  // a fault in the sequencer cannot hide behind its own state.
  logic [1:0] key_seen_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_seen_reg <= 2'h0;
    end else if (cmd_valid) begin
      if (ctrl_wr && cmd_wdata[7:6] == ilc_pkg::KEY_STEP1) begin
        key_seen_reg <= 2'h1;
      end else if (ctrl_wr && key_seen_reg == 2'h1 &&
          cmd_wdata[7:6] == ilc_pkg::KEY_STEP2) begin
        key_seen_reg <= 2'h2;
      end else begin
        key_seen_reg <= 2'h0;
      end
    end
  end

  sequence s_key3;
    key_seen_reg == 2'h2 && ctrl_wr && cmd_wdata[7:6] == ilc_pkg::KEY_STEP3;
  endsequence

  a_key_reset: assert property (s_key3 |=> soft_reset)
    else $error("key sequence did not reset");

  a_key_order: assert property (soft_reset |-> $past(key_seen_reg) == 2'h2 &&
    $past(ctrl_wr) && $past(cmd_wdata[7:6]) == ilc_pkg::KEY_STEP3)
    else $error("reset without full key sequence");

  a_key_cancel: assert property ((ctrl_wr && cmd_wdata[7:6] == ilc_pkg::KEY_STEP1) ##2
    (cmd_valid && !cmd_write && cmd_addr == ilc_pkg::ADDR_CTRL) ##2
    (ctrl_wr && cmd_wdata[7:6] == ilc_pkg::KEY_STEP2) ##2
    (ctrl_wr && cmd_wdata[7:6] == ilc_pkg::KEY_STEP3) |=> !soft_reset)
    else $error("read did not cancel key sequence");

  a_ctrl_resp: assert property (cmd_valid && cmd_addr == ilc_pkg::ADDR_CTRL |=>
    rsp_valid && rsp_data[7:6] == 2'h0 && rsp_data[5:0] == $past(ctrl_reg))
    else $error("control response wrong");

  a_lock_ctrl: assert property (lock_q && !key_fire |=> $stable(ctrl_reg))
    else $error("control bits changed after lock");

  a_phase_gate: assert property (!ctrl_reg[ilc_pkg::CTRL_PH_EN] && !key_fire |=>
    $stable(ctrl_reg[5:4]))
    else $error("phase changed with override off");

  a_phase_take: assert property (ctrl_wr && !lock_q && ctrl_reg[ilc_pkg::CTRL_PH_EN] &&
    !key_fire |=> ctrl_reg[5:4] == $past(cmd_wdata[5:4]))
    else $error("phase write not accepted");

  a_phase_hold: assert property (!lock_q && ctrl_reg[ilc_pkg::CTRL_PH_EN] |=>
    phase_hold && phase_sel == $past(ctrl_reg[5:4]))
    else $error("override phase not held");

  a_lock_normal: assert property (lock_q |=>
    phase_hold && phase_sel == ilc_pkg::PHASE_NORMAL)
    else $error("lock did not force normal phase");

  a_cfg_frozen: assert property (lock_q && !key_fire |=> $stable(cfg_reg))
    else $error("configuration changed after lock");

  a_cfg_take: assert property (cfg_wr && !lock_q && !key_fire |=>
    cfg_reg == $past(cmd_wdata))
    else $error("unlocked configuration write lost");

  a_lock_set: assert property (cfg_wr && !lock_q && cmd_wdata[5] && !key_fire |=>
    lock_q ##1 init_lock)
    else $error("lock not set by write");

  a_crc_gate: assert property (##1 crc_check_en == $past(lock_q))
    else $error("integrity check gating wrong");

  a_st_off: assert property (lock_q |=> !self_test_en)
    else $error("self test active while locked");

  a_st_follow: assert property (!lock_q |=> self_test_en == $past(self_test_control))
    else $error("self test enable does not follow its bit");

  a_src_sel: assert property (##1 data_source_select == $past(cfg_reg[7]))
    else $error("data source select wrong");

  a_fmt_sel: assert property (##1 output_format_select == $past(cfg_reg[4]))
    else $error("format select wrong");

  a_monitor: assert property (!cfg_reg[7] |=> offset_monitor_on)
    else $error("monitor not forced on");

  a_monitor_bit: assert property (cfg_reg[7] |=> offset_monitor_on == $past(cfg_reg[3]))
    else $error("monitor does not follow its bit");

  a_arm_decode: assert property (arm_field == 3'h1 |=> arm_mode == ilc_pkg::ARM_PCM)
    else $error("modulated code mode not decoded");

  a_arm_unfilt: assert property (arm_field[2:1] == 2'h3 |=>
    arm_mode == ilc_pkg::ARM_UNFILT)
    else $error("unfiltered mode not decoded");

  a_arm_float: assert property (arm_field == 3'h0 |=> !arm_drive_en)
    else $error("arming pin driven while disabled");

  a_arm_polarity: assert property (arm_field[2:1] != 2'h0 |=>
    arm_active_low == $past(arm_field[0]))
    else $error("arming polarity wrong");

  a_range_ro: assert property (cmd_valid && cmd_addr == ilc_pkg::ADDR_RANGE |=>
    rsp_hit && rsp_data == RANGE_CODE)
    else $error("range code response wrong");

  a_cfg_reject: assert property (cfg_wr && lock_q |=> rsp_data == $past(cfg_reg))
    else $error("rejected write response wrong");

  a_key_clear: assert property (soft_reset |=>
    cfg_reg == ilc_pkg::CFG_RST && ctrl_reg == ilc_pkg::CTRL_RST[5:0])
    else $error("key reset did not clear stores");

  a_key_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("key reset longer than one cycle");

  c_key_reset: cover property (s_key3 ##1 soft_reset);
  c_lock: cover property (cfg_wr && cmd_wdata[5] && !lock_q);
  c_phase_held: cover property (phase_hold && phase_sel == ilc_pkg::PHASE_START1);
  c_locked_write: cover property (cfg_wr && lock_q);
endmodule
`default_nettype wire

// *** ilc_host_model.sv ***
// Host model that issues single-byte register commands to the register bank.
`timescale 1ns/1ps
`default_nettype none
module ilc_host_model (
  // Clock
  input wire logic core_clk,
  // Command
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  // Response
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic [7:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
  end
  // Between commands the fields carry the inverse of the last value, so a bank that
  // samples them without a valid command cannot pass by luck.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [1:0] h);
    logic [7:0] dm;
    dm = (a == ilc_pkg::ADDR_CTRL) ? (d & 8'hf8) :
      ((a == ilc_pkg::ADDR_CFG) ? (d & 8'hbf) : d);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= dm;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_write <= ~w;
    cmd_addr <= ~a;
    cmd_wdata <= ~dm;
    #1;
    q = rsp_data;
    h = {rsp_valid, rsp_hit};
  endtask
endmodule
`default_nettype wire

// *** init_lock_control_config_regs_tb.sv ***
// Testbench for the lock, control and configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module init_lock_control_config_regs_tb;
  // Range variant code; the value is arbitrary.
  localparam logic [7:0] RANGE = 8'ha6;
  localparam logic [7:0] CT = ilc_pkg::ADDR_CTRL;
  localparam logic [7:0] CF = ilc_pkg::ADDR_CFG;
  logic core_clk, arst_n, self_test_control, cmd_valid, cmd_write, rsp_valid, rsp_hit;
  logic [7:0] cmd_addr, cmd_wdata, rsp_data, q, cfgv, prev;
  logic [1:0] h, phase_sel;
  logic [2:0] a, arm_mode;
  logic soft_reset, phase_hold, data_source_select, output_format_select, offset_monitor_on;
  logic arm_active_low, arm_drive_en, init_lock, crc_check_en, self_test_en;
  int errors, checks, fires, cycles;
  ilc_regs #(.RANGE_CODE(RANGE)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_data(rsp_data),
    .self_test_control(self_test_control), .soft_reset(soft_reset),
    .phase_hold(phase_hold), .phase_sel(phase_sel), .data_source_select(data_source_select),
    .output_format_select(output_format_select), .offset_monitor_on(offset_monitor_on),
    .arm_mode(arm_mode), .arm_active_low(arm_active_low), .arm_drive_en(arm_drive_en),
    .init_lock(init_lock), .crc_check_en(crc_check_en), .self_test_en(self_test_en));
  ilc_host_model u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
    .rsp_data(rsp_data));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d,
      input logic [7:0] e);
    u_host.xfer(w, ad, d, q, h);
    chk("rsp_data", e, q);
  endtask
  task automatic kw(input logic [1:0] k);
    u_host.xfer(1'b1, CT, {k, 6'h00}, q, h);
  endtask
  // Derived outputs follow the stores one cycle later.
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask
  // Soft reset pulses are counted all run long, so an unwanted one is never missed.
  always @(posedge core_clk) begin
    cycles++;
    if (soft_reset === 1'b1) fires++;
    if (cycles == 3000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    arst_n = 1'b0;
    self_test_control = 1'b1;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    settle;
    chk("reset_outputs", 8'h0c, {2'h0, init_lock, crc_check_en, self_test_en, offset_monitor_on,
      arm_drive_en, soft_reset});
    @(posedge core_clk);
    self_test_control <= 1'b0;
    settle;
    chk("self_test_en", 8'h00, {7'h00, self_test_en});
    @(posedge core_clk);
    self_test_control <= 1'b1;
    acc(0, ilc_pkg::ADDR_RANGE, 8'h00, RANGE);
    chk("rsp_hit", 8'h03, {6'h00, h});
    acc(1, ilc_pkg::ADDR_RANGE, 8'h3c, RANGE);
    acc(0, ilc_pkg::ADDR_RANGE, 8'h00, RANGE);
    acc(0, 8'h09, 8'h00, 8'h00);
    chk("rsp_hit", 8'h02, {6'h00, h});
    acc(0, CT, 8'h00, ilc_pkg::CTRL_RST);
    acc(0, CF, 8'h00, ilc_pkg::CFG_RST);
    $display("test reset_values done");
    acc(1, CT, 8'h30, 8'h00);
    acc(0, CT, 8'h00, 8'h00);
    acc(1, CT, 8'h08, 8'h00);
    acc(1, CT, 8'hd8, 8'h08);
    acc(0, CT, 8'h00, 8'h18);
    settle;
    chk("phase", 8'h05, {5'h00, phase_hold, phase_sel});
    $display("test phase_override done");
    prev = 8'h00;
    for (int i = 0; i < 8; i++) begin
      a = i[2:0];
      cfgv = {a[1], 2'b00, a[0], a[2], a};
      acc(1, CF, cfgv, prev);
      prev = cfgv;
      settle;
      chk("arm_mode", {5'h00, (a < 3'h2) ? a : 3'((a >> 1) + 3'h1)}, {5'h00, arm_mode});
      chk("cfg_outputs", {2'h0, a[1], a[0], a[2] | ~a[1], a[0] & (a > 3'h1), a != 3'h0, 1'b0},
        {2'h0, data_source_select, output_format_select, offset_monitor_on, arm_active_low,
        arm_drive_en, init_lock});
    end
    $display("test config_fields done");
    kw(2'h0);
    kw(2'h3);
    kw(2'h1);
    settle;
    chk("soft_reset_count", 8'h01, 8'(fires));
    acc(0, CF, 8'h00, 8'h00);
    kw(2'h0);
    acc(0, CT, 8'h00, 8'h00);
    kw(2'h3);
    kw(2'h1);
    kw(2'h0);
    acc(0, CF, 8'h00, 8'h00);
    kw(2'h3);
    kw(2'h1);
    kw(2'h0);
    kw(2'h2);
    kw(2'h1);
    settle;
    chk("soft_reset_count", 8'h01, 8'(fires));
    $display("test reset_key done");
    acc(1, CT, 8'h08, 8'h00);
    acc(1, CT, 8'h28, 8'h08);
    settle;
    chk("self_test_en", 8'h01, {7'h00, self_test_en});
    acc(1, CF, 8'h33, 8'h00);
    settle;
    chk("lock_outputs", 8'h37, {2'h0, init_lock, crc_check_en, self_test_en, phase_hold,
      phase_sel});
    acc(1, CF, 8'h80, 8'h33);
    acc(0, CF, 8'h00, 8'h33);
    acc(1, CT, 8'h10, 8'h28);
    acc(0, CT, 8'h00, 8'h28);
    settle;
    chk("phase_sel", 8'h03, {6'h00, phase_sel});
    kw(2'h0);
    kw(2'h3);
    kw(2'h1);
    settle;
    chk("soft_reset_count", 8'h02, 8'(fires));
    acc(0, CF, 8'h00, 8'h00);
    $display("test init_lock done");
    end_of_test;
  end
endmodule
`default_nettype wire
